// ---- shared/lpt_pkg.sv ----
// constants shared by the serial display-link transmitter
package lpt_pkg;
    localparam int PAIRS = 3;
    localparam int SLOTS = 7;
    localparam int COLOR_W = 6;
    localparam int WORD_W = 21;
    localparam int SLOT_W = 3;
    localparam int GAP_W = 5;
    localparam int EDGE_W = 4;
    localparam int TMR_W = 20;
    localparam logic [SLOT_W-1:0] FIRST_SLOT = 3'h0;
    localparam logic [SLOT_W-1:0] LAST_SLOT = 3'h6;
    // forwarded clock level per slot, slot 0 in bit 0
    localparam logic [SLOTS-1:0] CLK_PATTERN = 7'h63;
    // strobe edges needed before output is declared valid
    localparam logic [EDGE_W-1:0] LOCK_EDGES = 4'h8;
    // cycles without a strobe before the input clock counts as stopped
    localparam logic [GAP_W-1:0] STALL_CYC = 5'h1C;
    localparam int CLK_PERIOD_NS = 20;
    localparam int PD_DELAY_NS = 100;
    localparam int PD_DELAY_CYC = PD_DELAY_NS / CLK_PERIOD_NS;
    localparam int LOCK_TIME_MS = 10;
    localparam int LOCK_TIME_CYC = LOCK_TIME_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// ---- rtl/lpt_serializer_tx.sv ----
// serial display-link transmitter: capture, serialize, forward clock

module lpt_serializer_tx #(
    parameter int LOCK_LIMIT_CYCLES = lpt_pkg::LOCK_TIME_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins from the graphics source
    input wire logic pixel_clock_input,
    input wire logic strobe_edge_select,
    input wire logic power_down_n,
    input wire logic [lpt_pkg::COLOR_W-1:0] red,
    input wire logic [lpt_pkg::COLOR_W-1:0] green,
    input wire logic [lpt_pkg::COLOR_W-1:0] blue,
    input wire logic line_sync,
    input wire logic frame_sync,
    input wire logic pixel_data_valid,
    // serial side
    output logic [lpt_pkg::PAIRS-1:0] serial_data_pairs,
    output logic serial_data_oe,
    output logic forwarded_clock_pair,
    output logic forwarded_clock_oe,
    // status
    output logic link_locked
);
    logic pclk_s1_q, pclk_s2_q, pclk_s3_q;
    logic pd_s1_q, pd_s2_q;
    logic sel_s1_q, sel_s2_q;
    logic [lpt_pkg::WORD_W-1:0] word_s1_q, word_s2_q;
    logic [lpt_pkg::WORD_W-1:0] pins_word;
    logic run, rise, fall, strobe;

    logic [lpt_pkg::WORD_W-1:0] word_q, word_d;
    logic [lpt_pkg::SLOT_W-1:0] slot_q, slot_d;
    logic busy_q, busy_d;
    logic [lpt_pkg::GAP_W-1:0] gap_q, gap_d;
    logic [lpt_pkg::EDGE_W-1:0] edges_q, edges_d;
    logic locked_q, locked_d;
    logic [lpt_pkg::TMR_W-1:0] tmr_q, tmr_d;
    logic [lpt_pkg::PAIRS-1:0] dout_q, dout_d;
    logic cout_q, cout_d;
    logic doe_q, doe_d;
    logic coe_q, coe_d;
    logic map_bit0, map_bit_top;

    assign pins_word = {pixel_data_valid, frame_sync, line_sync,
                        blue, green, red};

    // two-flop synchronisers for every pin
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
            word_s1_q <= '0;
            word_s2_q <= '0;
        end
        else
        begin
            pclk_s1_q <= pixel_clock_input;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
            pd_s1_q <= power_down_n;
            pd_s2_q <= pd_s1_q;
            sel_s1_q <= strobe_edge_select;
            sel_s2_q <= sel_s1_q;
            word_s1_q <= pins_word;
            word_s2_q <= word_s1_q;
        end
    end

    assign run = pd_s2_q;
    assign rise = pclk_s2_q & ~pclk_s3_q;
    assign fall = ~pclk_s2_q & pclk_s3_q;
    assign strobe = sel_s2_q ? rise : fall;
    assign map_bit0 = word_q[slot_q];
    assign map_bit_top = word_q[(lpt_pkg::PAIRS - 1) * lpt_pkg::SLOTS
                                + int'(slot_q)];

    // capture, slot sequencing, lock tracking and output drive
    always_comb
    begin
        word_d = word_q;
        slot_d = slot_q;
        busy_d = busy_q;
        gap_d = gap_q;
        edges_d = edges_q;
        locked_d = locked_q;
        tmr_d = tmr_q;
        dout_d = '0;
        cout_d = 1'b0;
        doe_d = 1'b0;
        coe_d = 1'b0;
        if (!run)
        begin
            busy_d = 1'b0;
            slot_d = lpt_pkg::FIRST_SLOT;
            gap_d = '0;
            edges_d = '0;
            locked_d = 1'b0;
            tmr_d = '0;
        end
        else
        begin
            doe_d = 1'b1;
            coe_d = 1'b1;
            if (strobe)
            begin
                word_d = word_s2_q;
                slot_d = lpt_pkg::FIRST_SLOT;
                busy_d = 1'b1;
                gap_d = '0;
                if (edges_q != lpt_pkg::LOCK_EDGES)
                begin
                    edges_d = edges_q + 1'b1;
                end
            end
            else
            begin
                if (gap_q != lpt_pkg::STALL_CYC)
                begin
                    gap_d = gap_q + 1'b1;
                end
                if (busy_q)
                begin
                    if (slot_q == lpt_pkg::LAST_SLOT)
                    begin
                        busy_d = 1'b0;
                    end
                    else
                    begin
                        slot_d = slot_q + 1'b1;
                    end
                end
                if (gap_q == lpt_pkg::STALL_CYC)
                begin
                    edges_d = '0;
                    locked_d = 1'b0;
                    busy_d = 1'b0;
                end
            end
            if (edges_q == lpt_pkg::LOCK_EDGES && gap_q != lpt_pkg::STALL_CYC)
            begin
                locked_d = 1'b1;
            end
            if (!locked_q && edges_q != '0)
            begin
                tmr_d = tmr_q + 1'b1;
            end
            else
            begin
                tmr_d = '0;
            end
            if (locked_q && busy_q)
            begin
                for (int p = 0; p < lpt_pkg::PAIRS; p++)
                begin
                    dout_d[p] = word_q[p * lpt_pkg::SLOTS + int'(slot_q)];
                end
                cout_d = lpt_pkg::CLK_PATTERN[slot_q];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            word_q <= '0;
            slot_q <= lpt_pkg::FIRST_SLOT;
            busy_q <= 1'b0;
            gap_q <= '0;
            edges_q <= '0;
            locked_q <= 1'b0;
            tmr_q <= '0;
            dout_q <= '0;
            cout_q <= 1'b0;
            doe_q <= 1'b0;
            coe_q <= 1'b0;
        end
        else
        begin
            word_q <= word_d;
            slot_q <= slot_d;
            busy_q <= busy_d;
            gap_q <= gap_d;
            edges_q <= edges_d;
            locked_q <= locked_d;
            tmr_q <= tmr_d;
            dout_q <= dout_d;
            cout_q <= cout_d;
            doe_q <= doe_d;
            coe_q <= coe_d;
        end
    end

    assign serial_data_pairs = dout_q;
    assign forwarded_clock_pair = cout_q;
    assign serial_data_oe = doe_q;
    assign forwarded_clock_oe = coe_q;
    assign link_locked = locked_q;

    AST_PD_OFF: assert property (@(posedge clk)
        disable iff (!rst_n) !pd_s2_q
        |=> !serial_data_oe && !forwarded_clock_oe)
        else $error("outputs enabled during power-down");

    AST_PD_DELAY: assert property (@(posedge clk)
        disable iff (!rst_n) (!power_down_n)[*4]
        |=> !serial_data_oe && !forwarded_clock_oe)
        else $error("outputs not off within power-down delay");

    AST_FALL_EDGE: assert property (@(posedge clk)
        disable iff (!rst_n) (run && fall && !sel_s2_q)
        |=> busy_q && slot_q == lpt_pkg::FIRST_SLOT)
        else $error("falling edge strobe not taken");

    AST_RISE_EDGE: assert property (@(posedge clk)
        disable iff (!rst_n) (run && rise && sel_s2_q)
        |=> busy_q && slot_q == lpt_pkg::FIRST_SLOT)
        else $error("rising edge strobe not taken");

    AST_CAPTURE: assert property (@(posedge clk)
        disable iff (!rst_n) (run && strobe)
        |=> word_q == $past(word_s2_q))
        else $error("captured word differs from inputs");

    AST_NO_SPURIOUS: assert property (@(posedge clk)
        disable iff (!rst_n) (run && !strobe && !busy_q)
        |=> !busy_q)
        else $error("slot sequence started without strobe");

    AST_SLOT_STEP: assert property (@(posedge clk)
        disable iff (!rst_n) (run && busy_q && !strobe
            && slot_q != lpt_pkg::LAST_SLOT && gap_q != lpt_pkg::STALL_CYC)
        |=> slot_q == $past(slot_q) + 1'b1)
        else $error("slot did not advance by one");

    AST_IDLE_ZERO: assert property (@(posedge clk)
        disable iff (!rst_n) (run && busy_q && !strobe
            && slot_q == lpt_pkg::LAST_SLOT)
        |=> !busy_q ##1 serial_data_pairs == '0 && !forwarded_clock_pair)
        else $error("outputs not idle after last slot");

    AST_DATA_MAP: assert property (@(posedge clk)
        disable iff (!rst_n) (run && locked_q && busy_q)
        |=> serial_data_pairs[0] == $past(map_bit0))
        else $error("data pair bit not from its slot");

    AST_DATA_MAP_TOP: assert property (@(posedge clk)
        disable iff (!rst_n) (run && locked_q && busy_q)
        |=> serial_data_pairs[lpt_pkg::PAIRS-1] == $past(map_bit_top))
        else $error("top data pair bit not from its slot");

    AST_CLK_PATTERN: assert property (@(posedge clk)
        disable iff (!rst_n) (run && locked_q && busy_q)
        |=> forwarded_clock_pair == lpt_pkg::CLK_PATTERN[$past(slot_q)])
        else $error("forwarded clock pattern wrong");

    AST_STALL_UNLOCK: assert property (@(posedge clk)
        disable iff (!rst_n) (gap_q == lpt_pkg::STALL_CYC && !strobe)
        |=> !link_locked && edges_q == '0)
        else $error("stopped clock did not drop lock");

    AST_RESET_HOLD: assert property (@(posedge clk)
        disable iff (!rst_n) !run
        |=> !link_locked && !busy_q && tmr_q == '0)
        else $error("state not held in reset during power-down");

    AST_OE_ON: assert property (@(posedge clk)
        disable iff (!rst_n) run
        |=> serial_data_oe && forwarded_clock_oe)
        else $error("outputs not enabled outside power-down");

    AST_LOCK_SET: assert property (@(posedge clk)
        disable iff (!rst_n) (run && edges_q == lpt_pkg::LOCK_EDGES
            && gap_q != lpt_pkg::STALL_CYC)
        |=> link_locked)
        else $error("lock not taken after enough strobes");

    AST_UNLOCKED_QUIET: assert property (@(posedge clk)
        disable iff (!rst_n) !locked_q
        |=> serial_data_pairs == '0 && !forwarded_clock_pair)
        else $error("outputs driven before lock");

    AST_TMR_CLEAR: assert property (@(posedge clk)
        disable iff (!rst_n) (locked_q || edges_q == '0)
        |=> tmr_q == '0)
        else $error("lock timer not cleared");

    AST_LOCK_TIME: assert property (@(posedge clk)
        disable iff (!rst_n) tmr_q < LOCK_LIMIT_CYCLES)
        else $error("lock not reached within lock time");
endmodule

// ---- dv/lpt_rx_model.sv ----
// receiver model: rebuilds 21-bit words from the serial pairs
module lpt_rx_model (
    // serial side
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [lpt_pkg::PAIRS-1:0] pairs,
    input wire logic data_oe,
    input wire logic fclk,
    input wire logic fclk_oe,
    // rebuilt word
    output logic [lpt_pkg::WORD_W-1:0] word,
    output logic word_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [lpt_pkg::SLOTS-1:0] hc;
    logic [lpt_pkg::SLOTS-1:0] hd [lpt_pkg::PAIRS];
    // oldest slot ends in bit 0; a disabled pair reads as no clock
    always @(posedge clk)
    begin
        hc = {fclk & fclk_oe & data_oe, hc[6:1]};
        for (int p = 0; p < lpt_pkg::PAIRS; p++)
            hd[p] = {pairs[p], hd[p][6:1]};
        word_ok <= rst_n && hc === lpt_pkg::CLK_PATTERN;
        for (int p = 0; p < lpt_pkg::PAIRS; p++)
            word[p*7 +: 7] <= hd[p];
    end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the serial display-link transmitter
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst_n;
    logic pck;
    logic sel;
    logic pd_n;
    logic [20:0] din;
    logic [2:0] pairs;
    logic d_oe;
    logic fck;
    logic f_oe;
    logic locked;
    logic [20:0] rx_word;
    logic rx_ok;
    int miscompares;
    int total_checks;
    int cycles;
    int got;
    bit syncing;
    logic [20:0] exp_q[$];
    logic [20:0] corner [4] = '{21'h1FFFFF, 21'h0, 21'h155555, 21'h0AAAAA};

    lpt_serializer_tx #(.LOCK_LIMIT_CYCLES(200)) i_dut (
        .clk(clk), .rst_n(rst_n), .pixel_clock_input(pck),
        .strobe_edge_select(sel), .power_down_n(pd_n),
        .red(din[5:0]), .green(din[11:6]), .blue(din[17:12]),
        .line_sync(din[18]), .frame_sync(din[19]),
        .pixel_data_valid(din[20]), .serial_data_pairs(pairs),
        .serial_data_oe(d_oe), .forwarded_clock_pair(fck),
        .forwarded_clock_oe(f_oe), .link_locked(locked));
    lpt_rx_model i_rx (
        .clk(clk), .rst_n(rst_n), .pairs(pairs), .data_oe(d_oe),
        .fclk(fck), .fclk_oe(f_oe), .word(rx_word), .word_ok(rx_ok));

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one pixel: launch edge with new data, then the strobe edge
    task automatic pixels(int n, bit wobble);
        for (int i = 0; i < n; i++)
        begin
            pck <= !sel;
            din <= (i % 10 < 4) ? corner[i % 10] : 21'($urandom);
            repeat (4) @(posedge clk);
            pck <= sel;
            exp_q.push_back(din);
            if (i == 12)
                check("lock", {locked, d_oe, f_oe}, 3'h7);
            repeat (3 + (wobble ? $urandom_range(1) : 0)) @(posedge clk);
        end
    endtask

    task automatic run(string name, int n, bit wobble, int lo);
        syncing = 1;
        got = 0;
        pixels(n, wobble);
        repeat (40) @(posedge clk);
        check("word count", got >= lo, 1);
        check("lock lost", locked, 0);
        exp_q.delete();
        $display("test %s done", name);
    endtask

    task automatic pulse_pd();
        repeat (150) @(posedge clk);
        pd_n <= 0;
        repeat (5) @(posedge clk);
        #1 check("pd off", {d_oe, f_oe, locked, pairs, fck}, 0);
        repeat (55) @(posedge clk);
        pd_n <= 1;
        syncing = 1;
        for (int k = 0; k < 200 && locked !== 1'b1; k++)
            @(posedge clk);
        check("relock", locked, 1);
    endtask

    // words from the receiver are matched in order
    always @(posedge clk)
        if (rx_ok === 1'b1)
        begin
            while (syncing && exp_q.size() > 0 && exp_q[0] !== rx_word)
                void'(exp_q.pop_front());
            syncing = 0;
            got++;
            check("rx word", rx_word, exp_q.size() ? exp_q.pop_front() : 'x);
        end

    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            stop_test();
        end
    end

    initial
    begin
        void'($urandom(32'h6803));
        rst_n = 0;
        pck = 0;
        sel = 0;
        pd_n = 1;
        din = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1;
        repeat (20) @(posedge clk);
        run("falling", 40, 0, 30);
        sel <= 1;
        run("rising", 40, 1, 30);
        sel <= 0;
        fork
            run("powerdown", 60, 0, 20);
            pulse_pd();
        join
        run("resume", 30, 0, 20);
        stop_test();
    end
endmodule
